//--- lcim_pkg.sv
// constants for the link control and interrupt mask block
package lcim_pkg;

  // ---------------------------------------------------------------
  // register addresses and widths
  // ---------------------------------------------------------------
  localparam int          REG_AW         = 5;
  localparam int          REG_DW         = 16;
  localparam logic [4:0]  ADDR_LINK_CTRL = 5'h17;
  localparam logic [4:0]  ADDR_IRQ_MASK  = 5'h18;
  localparam logic [4:0]  ADDR_IRQ_STAT  = 5'h19;

  // ---------------------------------------------------------------
  // reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [15:0] LINK_CTRL_RST  = 16'h3048;
  localparam logic [15:0] IRQ_MASK_RST   = 16'h0000;
  localparam logic [15:0] LINK_CTRL_WMSK = 16'h3FFF;
  localparam int          LINK_EN_BIT    = 13;
  localparam int          RETRY_LSB      = 10;
  localparam int          RETRY_W        = 3;
  localparam int          PIN_EN_BIT     = 0;
  localparam int          EVT_LSB        = 1;
  localparam int          EVT_MSB        = 10;
  localparam int          NUM_EVT        = 10;

  // ---------------------------------------------------------------
  // link bring-up states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_STANDBY = 3'h1,
    ST_ATTEMPT = 3'h2,
    ST_LOWER   = 3'h4
  } lcim_link_e;

endpackage : lcim_pkg

//--- lcim_top.sv
// link control, retry count and interrupt mask registers of the phy
`timescale 1ns/1ps
`default_nettype none

module lcim_top
  import lcim_pkg::*;
(
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  // management register port
  input  wire logic [REG_AW-1:0]    reg_addr,
  input  wire logic                 reg_wr_en,
  input  wire logic [REG_DW-1:0]    reg_wdata,
  input  wire logic                 reg_rd_en,
  output logic      [REG_DW-1:0]    reg_rdata,
  output logic                      reg_rd_valid,
  // line-side link engine
  input  wire logic                 downspeed_enable,
  input  wire logic                 attempt_fail,
  input  wire logic                 link_up,
  output logic                      link_standby,
  output logic                      advertise_lower,
  // interrupt sources, bit n is status bit n
  input  wire logic [EVT_MSB:EVT_LSB] event_in,
  // interrupt pin
  output logic                      int_n
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [REG_DW-1:0]      ctrl_q;
  logic [REG_DW-1:0]      mask_q;
  logic [EVT_MSB:EVT_LSB] stat_q;
  logic [EVT_MSB:EVT_LSB] stat_d;
  logic                   pend_q;
  logic                   pend_d;
  logic                   stat_rd;
  logic [RETRY_W-1:0]     retry_cnt;
  logic [RETRY_W-1:0]     fail_q;
  lcim_link_e             link_q;

  assign stat_rd   = reg_rd_en && (reg_addr == ADDR_IRQ_STAT);
  assign retry_cnt = ctrl_q[RETRY_LSB +: RETRY_W];

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_q <= LINK_CTRL_RST;
    end else if (reg_wr_en && reg_addr == ADDR_LINK_CTRL) begin
      ctrl_q <= reg_wdata & LINK_CTRL_WMSK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mask_q <= IRQ_MASK_RST;
    end else if (reg_wr_en && reg_addr == ADDR_IRQ_MASK) begin
      mask_q <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // read port, data one cycle after the strobe
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata    <= 16'h0000;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        case (reg_addr)
          ADDR_LINK_CTRL: reg_rdata <= ctrl_q;
          ADDR_IRQ_MASK:  reg_rdata <= mask_q;
          ADDR_IRQ_STAT:  reg_rdata <= {5'h00, stat_q, pend_q};
          default:        reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt status and pin
  // ---------------------------------------------------------------
  // new events win over the clearing read
  assign stat_d = (stat_rd ? '0 : stat_q) | event_in;
  assign pend_d = |(stat_d & mask_q[EVT_MSB:EVT_LSB]);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stat_q <= '0;
      pend_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      pend_q <= pend_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      int_n <= 1'b1;
    end else begin
      int_n <= !(mask_q[PIN_EN_BIT] && pend_d);
    end
  end

  // ---------------------------------------------------------------
  // link bring-up and downspeed
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      link_q <= ST_STANDBY;
      fail_q <= '0;
    end else begin
      case (link_q)
        ST_STANDBY: begin
          fail_q <= '0;
          if (ctrl_q[LINK_EN_BIT]) begin
            link_q <= ST_ATTEMPT;
          end
        end
        ST_ATTEMPT: begin
          if (!ctrl_q[LINK_EN_BIT]) begin
            link_q <= ST_STANDBY;
          end else if (link_up) begin
            fail_q <= '0;
          end else if (attempt_fail) begin
            if (downspeed_enable && fail_q >= retry_cnt) begin
              link_q <= ST_LOWER;
            end else if (fail_q != '1) begin
              fail_q <= fail_q + 3'h1;
            end
          end
        end
        ST_LOWER: begin
          fail_q <= '0;
          if (!ctrl_q[LINK_EN_BIT]) begin
            link_q <= ST_STANDBY;
          end else if (!downspeed_enable) begin
            link_q <= ST_ATTEMPT;
          end
        end
        default: link_q <= ST_STANDBY;
      endcase
    end
  end

  assign link_standby    = (link_q == ST_STANDBY);
  assign advertise_lower = (link_q == ST_LOWER) && downspeed_enable;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_stat_read;
    reg_rd_en && reg_addr == ADDR_IRQ_STAT;
  endsequence

  sequence s_quiet;
    event_in == '0 && !reg_wr_en;
  endsequence

  property p_standby;
    @(posedge sys_clk) disable iff (!rst_n)
      !ctrl_q[LINK_EN_BIT] |=> link_standby && !advertise_lower;
  endproperty
  a_standby: assert property (p_standby) else $error("link not in standby");

  property p_reset_vals;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(rst_n) |-> ctrl_q == 16'h3048 && mask_q == 16'h0000 && int_n;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

  property p_top_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      ctrl_q[15:14] == 2'h0;
  endproperty
  a_top_zero: assert property (p_top_zero) else $error("reserved bits set");

  // five failures with default count, downspeed on, then lower speed
  sequence s_fail_run;
    (attempt_fail && !link_up && downspeed_enable && ctrl_q[LINK_EN_BIT]
     && retry_cnt == 3'h4 && link_q == ST_ATTEMPT && fail_q == 3'h0)
    ##1 (attempt_fail && !link_up && downspeed_enable && ctrl_q[LINK_EN_BIT]
         && retry_cnt == 3'h4) [*4];
  endsequence

  property p_five_tries;
    @(posedge sys_clk) disable iff (!rst_n)
      s_fail_run |=> advertise_lower;
  endproperty
  a_five_tries: assert property (p_five_tries) else $error("no downspeed");

  property p_early;
    @(posedge sys_clk) disable iff (!rst_n)
      link_q == ST_ATTEMPT && fail_q < retry_cnt |=> !advertise_lower;
  endproperty
  a_early: assert property (p_early) else $error("downspeed too early");

  property p_no_ds;
    @(posedge sys_clk) disable iff (!rst_n)
      !downspeed_enable |-> !advertise_lower ##1 (link_q != ST_LOWER);
  endproperty
  a_no_ds: assert property (p_no_ds) else $error("lower speed w/o downspeed");

  genvar gi;
  for (gi = EVT_LSB; gi <= EVT_MSB; gi++) begin : g_evt
    property p_latch;
      @(posedge sys_clk) disable iff (!rst_n)
        event_in[gi] |=> stat_q[gi];
    endproperty
    a_latch: assert property (p_latch) else $error("event not latched");

    property p_gate;
      @(posedge sys_clk) disable iff (!rst_n)
        event_in[gi] && mask_q[gi] && mask_q[PIN_EN_BIT] && !reg_wr_en |=> !int_n;
    endproperty
    a_gate: assert property (p_gate) else $error("enabled event no irq");
  end

  property p_clear;
    @(posedge sys_clk) disable iff (!rst_n)
      s_stat_read and (event_in == '0) |=> stat_q == '0 && !pend_q;
  endproperty
  a_clear: assert property (p_clear) else $error("read did not clear");

  property p_masked;
    @(posedge sys_clk) disable iff (!rst_n)
      (stat_d & mask_q[EVT_MSB:EVT_LSB]) == '0 |=> int_n;
  endproperty
  a_masked: assert property (p_masked) else $error("irq from disabled source");

  property p_pin_off;
    @(posedge sys_clk) disable iff (!rst_n)
      !mask_q[PIN_EN_BIT] |=> int_n;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin asserted while off");

  property p_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      !int_n ##0 (!reg_rd_en && !reg_wr_en && $stable(mask_q)) |=> !int_n;
  endproperty
  a_hold: assert property (p_hold) else $error("irq dropped w/o read");

  property p_release;
    @(posedge sys_clk) disable iff (!rst_n)
      !int_n ##0 s_stat_read ##0 s_quiet |=> int_n;
  endproperty
  a_release: assert property (p_release) else $error("irq held after read");

  property p_pend_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      pend_q && !reg_rd_en && !reg_wr_en && $stable(mask_q) |=> pend_q;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending lost");

  property p_lower_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      link_q == ST_LOWER && ctrl_q[LINK_EN_BIT] && downspeed_enable |=> link_q == ST_LOWER;
  endproperty
  a_lower_hold: assert property (p_lower_hold) else $error("lower speed lost");

  property p_rd_valid;
    @(posedge sys_clk) disable iff (!rst_n)
      reg_rd_en |=> reg_rd_valid;
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("no read valid");

  property p_rd_ctrl;
    @(posedge sys_clk) disable iff (!rst_n)
      reg_rd_en && reg_addr == ADDR_LINK_CTRL |=> reg_rdata[15:14] == 2'h0;
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("reserved bits read");

  property p_wr_mask;
    @(posedge sys_clk) disable iff (!rst_n)
      reg_wr_en && reg_addr == ADDR_IRQ_MASK |=> mask_q == $past(reg_wdata);
  endproperty
  a_wr_mask: assert property (p_wr_mask) else $error("mask write lost");

endmodule : lcim_top

`default_nettype wire

//--- lcim_line_model.sv
// line-side engine model: attempt failures and interrupt sources
`timescale 1ns/1ps
`default_nettype none
module lcim_line_model
  import lcim_pkg::*;
(
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  // requests from the bench
  input  wire logic                   fail_req,
  input  wire logic [EVT_MSB:EVT_LSB] event_req,
  // towards the device
  output logic                        attempt_fail,
  output logic [EVT_MSB:EVT_LSB]      event_in
);
  // requests registered and passed on cycle for cycle, quiet in reset
  always_ff @(posedge sys_clk) begin
    attempt_fail <= rst_n & fail_req;
    event_in     <= rst_n ? event_req : '0;
  end
endmodule : lcim_line_model
`default_nettype wire

//--- tb.sv
// self-checking bench for the link control and interrupt mask block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lcim_pkg::*;
  logic                   sys_clk, rst_n, reg_wr_en, reg_rd_en, reg_rd_valid;
  logic [REG_AW-1:0]      reg_addr;
  logic [REG_DW-1:0]      reg_wdata, reg_rdata;
  logic                   downspeed_enable, attempt_fail, link_up, fail_req;
  logic                   link_standby, advertise_lower, int_n;
  logic [EVT_MSB:EVT_LSB] event_in, event_req;
  int                     miscompares = 0;
  int                     comparisons = 0;

  lcim_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .downspeed_enable(downspeed_enable), .attempt_fail(attempt_fail), .link_up(link_up),
    .link_standby(link_standby), .advertise_lower(advertise_lower),
    .event_in(event_in), .int_n(int_n));
  lcim_line_model line (.sys_clk(sys_clk), .rst_n(rst_n), .fail_req(fail_req),
    .event_req(event_req), .attempt_fail(attempt_fail), .event_in(event_in));

  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [15:0] exp, input logic [15:0] m);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    #1;
    chk("read valid", 16'h1, {15'h0, reg_rd_valid});
    chk("read data", exp & m, reg_rdata & m);
  endtask : rd

  // pulse one source, then let the pin settle
  task automatic ev(input int n);
    logic [15:0] b;
    b = 16'h0001 << n;
    @(posedge sys_clk);
    event_req <= b[EVT_MSB:EVT_LSB];
    @(posedge sys_clk);
    event_req <= '0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : ev

  task automatic fail(input int k, input logic exp);
    repeat (k) begin
      @(posedge sys_clk);
      fail_req <= 1'b1;
      @(posedge sys_clk);
      fail_req <= 1'b0;
    end
    repeat (2) @(posedge sys_clk);
    #1;
    chk("advertise_lower", {15'h0, exp}, {15'h0, advertise_lower});
  endtask : fail

  task automatic results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  // ---------------------------------------------------------------
  // clock and watchdog
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial begin
    #500000;
    miscompares++;
    results();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    {rst_n, reg_wr_en, reg_rd_en, downspeed_enable, link_up, fail_req} = '0;
    reg_addr  = '0;
    reg_wdata = '0;
    event_req = '0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(ADDR_LINK_CTRL, 16'h3048, 16'hFFFF);
    rd(ADDR_IRQ_MASK, 16'h0000, 16'hFFFF);
    chk("int_n", 16'h1, {15'h0, int_n});
    chk("link_standby", 16'h0, {15'h0, link_standby});
    wr(ADDR_LINK_CTRL, 16'hFFFF);
    rd(ADDR_LINK_CTRL, 16'h3FFF, 16'hFFFF);
    wr(ADDR_LINK_CTRL, 16'h3048);
    wr(ADDR_IRQ_MASK, 16'hFFFF);
    rd(ADDR_IRQ_MASK, 16'hFFFF, 16'hFFFF);
    rd(5'h1F, 16'h0000, 16'hFFFF);
    $display("test registers done");

    for (int n = 1; n <= NUM_EVT; n++) begin
      wr(ADDR_IRQ_MASK, 16'h0001 | (16'h0001 << n));
      ev(n);
      chk("int_n", 16'h0, {15'h0, int_n});
      rd(ADDR_IRQ_STAT, 16'h0001 | (16'h0001 << n), 16'hFFFF);
      chk("int_n", 16'h1, {15'h0, int_n});
      wr(ADDR_IRQ_MASK, 16'h0001);
      ev(n);
      chk("int_n", 16'h1, {15'h0, int_n});
      rd(ADDR_IRQ_STAT, 16'h0001 << n, 16'hFFFF);
      wr(ADDR_IRQ_MASK, 16'h0001 << n);
      ev(n);
      chk("int_n", 16'h1, {15'h0, int_n});
      rd(ADDR_IRQ_STAT, 16'h0001 | (16'h0001 << n), 16'hFFFF);
    end
    $display("test interrupts done");

    @(posedge sys_clk);
    downspeed_enable <= 1'b1;
    fail(4, 1'b0);
    fail(1, 1'b1);
    wr(ADDR_LINK_CTRL, 16'h1048);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("link_standby", 16'h1, {15'h0, link_standby});
    fail(2, 1'b0);
    wr(ADDR_LINK_CTRL, 16'h2448);
    @(posedge sys_clk);
    link_up <= 1'b1;
    @(posedge sys_clk);
    link_up <= 1'b0;
    fail(1, 1'b0);
    fail(1, 1'b1);
    @(posedge sys_clk);
    downspeed_enable <= 1'b0;
    wr(ADDR_LINK_CTRL, 16'h0448);
    wr(ADDR_LINK_CTRL, 16'h2448);
    fail(8, 1'b0);
    // five failures back to back from a fresh count
    @(posedge sys_clk);
    downspeed_enable <= 1'b1;
    wr(ADDR_LINK_CTRL, 16'h1048);
    wr(ADDR_LINK_CTRL, 16'h3048);
    @(posedge sys_clk);
    fail_req <= 1'b1;
    repeat (5) @(posedge sys_clk);
    fail_req <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("advertise_lower", 16'h1, {15'h0, advertise_lower});
    $display("test link done");
    results();
  end
endmodule : tb
`default_nettype wire
